// [design/async_timer_pkg.sv]
// constants, register map and field layouts for the asynchronous 8-bit timer control block
// assumes one 20 MHz register clock and 32-bit Avalon-MM words, one register per word
package async_timer_pkg;

    // clock figures
    localparam int REF_CLK_HZ        = 20000000;
    localparam int CLK_PERIOD_NS     = 1000000000 / REF_CLK_HZ;

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_INT_MASK   = 8'h70;
    localparam logic [7:0] IDX_ASYNC_STAT = 8'hB6;
    localparam logic [7:0] IDX_CTRL_A     = 8'hB0;
    localparam logic [7:0] IDX_CTRL_B     = 8'hB1;
    localparam logic [7:0] IDX_COUNT      = 8'hB2;
    localparam logic [7:0] IDX_CMP_A      = 8'hB3;
    localparam logic [7:0] IDX_CMP_B      = 8'hB4;
    localparam logic [7:0] IDX_INT_FLAGS  = 8'h37;
    localparam logic [7:0] IDX_GEN_CTRL   = 8'h43;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // bit positions
    localparam int BIT_FORCE_A   = 7;
    localparam int BIT_FORCE_B   = 6;
    localparam int BIT_EXT_CLK   = 6;
    localparam int BIT_ASYNC_SEL = 5;
    localparam int BIT_SYNC_MODE = 7;
    localparam int BIT_PSR_ASY   = 1;
    localparam int BIT_PSR_SYNC  = 0;
    localparam int BIT_IRQ_CMPB  = 2;
    localparam int BIT_IRQ_CMPA  = 1;
    localparam int BIT_IRQ_OVF   = 0;

    // update-busy slots, also their bit positions in the status register
    localparam int UB_COUNT  = 4;
    localparam int UB_CMP_A  = 3;
    localparam int UB_CMP_B  = 2;
    localparam int UB_CTRL_A = 1;
    localparam int UB_CTRL_B = 0;
    localparam int UB_NUM    = 5;

    // timer-clock edges needed to move a value out of temporary storage
    localparam logic [1:0] XFER_EDGES = 2'h2;

    // counter limits
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;

    // clock-select codes and prescaler tap masks (divide by mask plus one)
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam int PRESC_W = 10;
    localparam logic [PRESC_W-1:0] TAP_8    = 10'h007;
    localparam logic [PRESC_W-1:0] TAP_32   = 10'h01F;
    localparam logic [PRESC_W-1:0] TAP_64   = 10'h03F;
    localparam logic [PRESC_W-1:0] TAP_128  = 10'h07F;
    localparam logic [PRESC_W-1:0] TAP_256  = 10'h0FF;
    localparam logic [PRESC_W-1:0] TAP_1024 = 10'h3FF;

    // compare output mode codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // waveform mode low-bit codes
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE  = 2'h1;
    localparam logic [1:0] WGM_CTC    = 2'h2;
    localparam logic [1:0] WGM_FAST   = 2'h3;

    // control register A layout
    typedef struct packed {
        logic [1:0] output_mode_a;
        logic [1:0] output_mode_b;
        logic [1:0] reserved;
        logic [1:0] waveform_mode_low;
    } ctrl_a_t;

    // control register B layout
    typedef struct packed {
        logic       force_compare_a;
        logic       force_compare_b;
        logic [1:0] reserved;
        logic       waveform_mode_top_bit;
        logic [2:0] clock_select_field;
    } ctrl_b_t;

    // interrupt request group: compare b, compare a, overflow
    typedef struct packed {
        logic cmp_b;
        logic cmp_a;
        logic ovf;
    } irq_vec_t;

endpackage : async_timer_pkg

// [design/async_timer_ctrl.sv]
// asynchronous 8-bit timer/counter with its register interface on Avalon-MM
// assumes osc_input_pin is sampled on i_ref_clk and is far slower than it
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module async_timer_ctrl
    import async_timer_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_osc_input_pin,
    input  wire logic        i_global_irq_enable,
    input  wire irq_vec_t    i_irq_ack,
    output irq_vec_t         o_irq_req,
    output logic             o_wave_out_a,
    output logic             o_wave_out_b,
    output logic             o_wave_en_a,
    output logic             o_wave_en_b,
    output logic             o_crystal_osc_run,
    output logic             o_ext_clock_buf_en,
    output logic             o_shared_prescaler_reset
);

    // byte address of an index
    function automatic logic [9:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction : reg_addr

    // prescaler tap reached for a clock-select code
    function automatic logic tap_hit(input logic [2:0] cs, input logic [PRESC_W-1:0] p);
        case (cs)
            3'h2:    tap_hit = (p & TAP_8) == TAP_8;
            3'h3:    tap_hit = (p & TAP_32) == TAP_32;
            3'h4:    tap_hit = (p & TAP_64) == TAP_64;
            3'h5:    tap_hit = (p & TAP_128) == TAP_128;
            3'h6:    tap_hit = (p & TAP_256) == TAP_256;
            3'h7:    tap_hit = p == TAP_1024;
            CS_DIV1: tap_hit = 1'b1;
            default: tap_hit = 1'b0;
        endcase
    endfunction : tap_hit

    // next pin level for a non-PWM compare event
    function automatic logic com_event(input logic [1:0] com, input logic cur);
        case (com)
            COM_TOGGLE: com_event = ~cur;
            COM_CLEAR:  com_event = 1'b0;
            COM_SET:    com_event = 1'b1;
            default:    com_event = cur;
        endcase
    endfunction : com_event

    logic             ack_r;
    logic [31:0]      rdata_r;
    logic [2:0]       irq_en_r;
    logic             ext_clk_r;
    logic             async_sel_r;
    logic             sync_mode_r;
    logic             psr_asy_r;
    logic             psr_sync_r;
    logic [2:0]       flags_r;
    logic [7:0]       count_r;
    logic [7:0]       cmp_a_r;
    logic [7:0]       cmp_b_r;
    ctrl_a_t          ctla_r;
    ctrl_b_t          ctlb_r;
    logic [7:0]       t_count_r;
    logic [7:0]       t_cmp_a_r;
    logic [7:0]       t_cmp_b_r;
    ctrl_a_t          t_ctla_r;
    ctrl_b_t          t_ctlb_r;
    logic [UB_NUM-1:0] busy_r;
    logic [UB_NUM-1:0] sync_apply_r;
    logic [1:0]       xfer_cnt_r [UB_NUM];
    logic [UB_NUM-1:0] apply;
    logic [UB_NUM-1:0] wr_hit;
    logic             osc_meta_r;
    logic             osc_sync_r;
    logic             osc_prev_r;
    logic             osc_rise;
    logic [PRESC_W-1:0] presc_r;
    logic             src_tick;
    logic             tick;
    logic             block_r;
    logic             down_r;
    logic             out_a_r;
    logic             out_b_r;
    logic             wr_go;
    logic [7:0]       wd;
    logic [2:0]       wgm;
    logic             is_pwm;
    logic [7:0]       top;
    logic             match_a;
    logic             match_b;
    logic             at_top;
    logic             wrap;
    logic             ovf_evt;
    logic             force_a;
    logic             force_b;

    // bus handshake: one wait cycle, then the access completes
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
    assign wr_go = i_avs_write & ack_r & i_avs_byteenable[0];
    assign wd    = i_avs_writedata[7:0];
    assign o_avs_readdata = rdata_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) ack_r <= 1'b0;
        else         ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
    end

    // read decode, captured one cycle before the answer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_avs_address == reg_addr(IDX_INT_MASK)) begin
            rdata_r <= {29'h0, irq_en_r};
        end else if (i_avs_address == reg_addr(IDX_ASYNC_STAT)) begin
            rdata_r <= {24'h0, 1'b0, ext_clk_r, async_sel_r, busy_r};
        end else if (i_avs_address == reg_addr(IDX_INT_FLAGS)) begin
            rdata_r <= {29'h0, flags_r};
        end else if (i_avs_address == reg_addr(IDX_GEN_CTRL)) begin
            rdata_r <= {24'h0, sync_mode_r, 5'h00, psr_asy_r, psr_sync_r};
        end else if (i_avs_address == reg_addr(IDX_COUNT)) begin
            rdata_r <= {24'h0, count_r};
        end else if (i_avs_address == reg_addr(IDX_CMP_A)) begin
            rdata_r <= {24'h0, t_cmp_a_r};
        end else if (i_avs_address == reg_addr(IDX_CMP_B)) begin
            rdata_r <= {24'h0, t_cmp_b_r};
        end else if (i_avs_address == reg_addr(IDX_CTRL_A)) begin
            rdata_r <= {24'h0, t_ctla_r.output_mode_a, t_ctla_r.output_mode_b,
                        2'b00, t_ctla_r.waveform_mode_low};
        end else if (i_avs_address == reg_addr(IDX_CTRL_B)) begin
            rdata_r <= {24'h0, 2'b00, 2'b00, t_ctlb_r.waveform_mode_top_bit,
                        t_ctlb_r.clock_select_field};
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    // write strobes of the five timer-domain registers
    always_comb begin
        wr_hit = '0;
        wr_hit[UB_COUNT]  = wr_go & (i_avs_address == reg_addr(IDX_COUNT));
        wr_hit[UB_CMP_A]  = wr_go & (i_avs_address == reg_addr(IDX_CMP_A));
        wr_hit[UB_CMP_B]  = wr_go & (i_avs_address == reg_addr(IDX_CMP_B));
        wr_hit[UB_CTRL_A] = wr_go & (i_avs_address == reg_addr(IDX_CTRL_A));
        wr_hit[UB_CTRL_B] = wr_go & (i_avs_address == reg_addr(IDX_CTRL_B));
    end

    // temporary storage, always the latest software value
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            t_count_r <= RST_BYTE;
            t_cmp_a_r <= RST_BYTE;
            t_cmp_b_r <= RST_BYTE;
            t_ctla_r  <= ctrl_a_t'(RST_BYTE);
            t_ctlb_r  <= ctrl_b_t'(RST_BYTE);
        end else begin
            if (wr_hit[UB_COUNT])  t_count_r <= wd;
            if (wr_hit[UB_CMP_A])  t_cmp_a_r <= wd;
            if (wr_hit[UB_CMP_B])  t_cmp_b_r <= wd;
            if (wr_hit[UB_CTRL_A]) t_ctla_r  <= ctrl_a_t'(wd);
            if (wr_hit[UB_CTRL_B]) t_ctlb_r  <= ctrl_b_t'(wd);
        end
    end

    // synchronous mode: transfer on the cycle after the write
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) sync_apply_r <= '0;
        else         sync_apply_r <= async_sel_r ? '0 : wr_hit;
    end

    // oscillator pin sampling and rising-edge detect
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= i_osc_input_pin;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end
    assign osc_rise = osc_sync_r & ~osc_prev_r;

    // asynchronous mode: busy until enough timer-clock edges have passed
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            busy_r <= '0;
            for (int i = 0; i < UB_NUM; i++) xfer_cnt_r[i] <= 2'h0;
        end else begin
            for (int i = 0; i < UB_NUM; i++) begin
                if (wr_hit[i] && async_sel_r) begin
                    busy_r[i]     <= 1'b1;
                    xfer_cnt_r[i] <= 2'h0;
                end else if (busy_r[i] && osc_rise) begin
                    if (xfer_cnt_r[i] == XFER_EDGES - 2'h1) begin
                        busy_r[i]     <= 1'b0;
                        xfer_cnt_r[i] <= 2'h0;
                    end else begin
                        xfer_cnt_r[i] <= xfer_cnt_r[i] + 2'h1;
                    end
                end
            end
        end
    end

    // transfer moments of each slot
    always_comb begin
        for (int i = 0; i < UB_NUM; i++) begin
            apply[i] = sync_apply_r[i] |
                       (busy_r[i] & osc_rise & ~wr_hit[i] &
                        (xfer_cnt_r[i] == XFER_EDGES - 2'h1));
        end
    end

    // live compare and control registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            cmp_a_r <= RST_BYTE;
            cmp_b_r <= RST_BYTE;
            ctla_r  <= ctrl_a_t'(RST_BYTE);
            ctlb_r  <= ctrl_b_t'(RST_BYTE);
        end else begin
            if (apply[UB_CMP_A])  cmp_a_r <= t_cmp_a_r;
            if (apply[UB_CMP_B])  cmp_b_r <= t_cmp_b_r;
            if (apply[UB_CTRL_A]) ctla_r  <= t_ctla_r;
            if (apply[UB_CTRL_B]) ctlb_r  <= t_ctlb_r;
        end
    end

    // interrupt enables and clock source controls
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            irq_en_r    <= 3'h0;
            ext_clk_r   <= 1'b0;
            async_sel_r <= 1'b0;
        end else begin
            if (wr_go && i_avs_address == reg_addr(IDX_INT_MASK)) irq_en_r <= wd[2:0];
            if (wr_go && i_avs_address == reg_addr(IDX_ASYNC_STAT)) begin
                ext_clk_r   <= wd[BIT_EXT_CLK];
                async_sel_r <= wd[BIT_ASYNC_SEL];
            end
        end
    end
    assign o_crystal_osc_run  = ~ext_clk_r;
    assign o_ext_clock_buf_en = ext_clk_r & async_sel_r;

    // prescaler reset bits and synchronisation mode
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sync_mode_r <= 1'b0;
            psr_asy_r   <= 1'b0;
            psr_sync_r  <= 1'b0;
        end else if (wr_go && i_avs_address == reg_addr(IDX_GEN_CTRL)) begin
            sync_mode_r <= wd[BIT_SYNC_MODE];
            psr_asy_r   <= wd[BIT_PSR_ASY] | (psr_asy_r & wd[BIT_SYNC_MODE]);
            psr_sync_r  <= wd[BIT_PSR_SYNC] | (psr_sync_r & wd[BIT_SYNC_MODE]);
        end else if (!sync_mode_r) begin
            psr_sync_r <= 1'b0;
            if (!async_sel_r || osc_rise) psr_asy_r <= 1'b0;
        end
    end
    assign o_shared_prescaler_reset = psr_sync_r;

    // timer source clock and own prescaler
    assign src_tick = async_sel_r ? osc_rise : 1'b1;
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || psr_asy_r) presc_r <= '0;
        else if (src_tick)        presc_r <= presc_r + 1'b1;
    end
    assign tick = src_tick & ~psr_asy_r & tap_hit(ctlb_r.clock_select_field, presc_r);

    // waveform mode decode
    assign wgm    = {ctlb_r.waveform_mode_top_bit, ctla_r.waveform_mode_low};
    assign is_pwm = wgm[0];
    assign top    = (wgm[2] || wgm[1:0] == WGM_CTC) ? cmp_a_r : CNT_MAX;
    assign at_top = count_r == top;

    // compare matches, blocked on the tick after a counter write
    assign match_a = tick & ~block_r & (count_r == cmp_a_r);
    assign match_b = tick & ~block_r & (count_r == cmp_b_r);

    // forced compares: strobe on the control B transfer, non-PWM only
    assign force_a = apply[UB_CTRL_B] & t_ctlb_r.force_compare_a & ~t_ctla_r.waveform_mode_low[0]
                     & ~t_ctlb_r.waveform_mode_top_bit;
    assign force_b = apply[UB_CTRL_B] & t_ctlb_r.force_compare_b & ~t_ctla_r.waveform_mode_low[0]
                     & ~t_ctlb_r.waveform_mode_top_bit;

    // wrap and overflow events
    assign wrap    = tick & at_top & (wgm[1:0] != WGM_PHASE);
    assign ovf_evt = (wgm[1:0] == WGM_PHASE) ? (tick & down_r & count_r == CNT_BOTTOM)
                   : (wgm[1:0] == WGM_FAST)  ? wrap
                   : (tick & count_r == CNT_MAX);

    // counter, direction and write blocking
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            count_r <= RST_BYTE;
            down_r  <= 1'b0;
            block_r <= 1'b0;
        end else if (apply[UB_COUNT]) begin
            count_r <= t_count_r;
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
            if (wgm[1:0] == WGM_PHASE) begin
                if (at_top && !down_r) begin
                    down_r  <= 1'b1;
                    count_r <= count_r - 8'h01;
                end else if (count_r == CNT_BOTTOM && down_r) begin
                    down_r  <= 1'b0;
                    count_r <= count_r + 8'h01;
                end else begin
                    count_r <= down_r ? count_r - 8'h01 : count_r + 8'h01;
                end
            end else if (wgm[1:0] == WGM_NORMAL) begin
                count_r <= count_r + 8'h01;
            end else begin
                count_r <= at_top ? CNT_BOTTOM : count_r + 8'h01;
            end
        end
    end

    // waveform outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            out_a_r <= 1'b0;
            out_b_r <= 1'b0;
        end else if (!is_pwm) begin
            if (match_a || force_a) out_a_r <= com_event(ctla_r.output_mode_a, out_a_r);
            if (match_b || force_b) out_b_r <= com_event(ctla_r.output_mode_b, out_b_r);
        end else if (wgm[1:0] == WGM_FAST) begin
            if (match_a && ctla_r.output_mode_a == COM_TOGGLE && wgm[2]) out_a_r <= ~out_a_r;
            else if (match_a && ctla_r.output_mode_a[1]) out_a_r <= ctla_r.output_mode_a[0];
            else if (wrap && ctla_r.output_mode_a[1]) out_a_r <= ~ctla_r.output_mode_a[0];
            if (match_b && ctla_r.output_mode_b[1]) out_b_r <= ctla_r.output_mode_b[0];
            else if (wrap && ctla_r.output_mode_b[1]) out_b_r <= ~ctla_r.output_mode_b[0];
        end else begin
            if (match_a && ctla_r.output_mode_a == COM_TOGGLE && wgm[2]) out_a_r <= ~out_a_r;
            else if (match_a && ctla_r.output_mode_a[1])
                out_a_r <= ctla_r.output_mode_a[0] ^ down_r;
            if (match_b && ctla_r.output_mode_b[1])
                out_b_r <= ctla_r.output_mode_b[0] ^ down_r;
        end
    end
    assign o_wave_out_a = out_a_r;
    assign o_wave_out_b = out_b_r;
    assign o_wave_en_a  = (ctla_r.output_mode_a != COM_OFF) &
                          !(is_pwm && ctla_r.output_mode_a == COM_TOGGLE && !wgm[2]);
    assign o_wave_en_b  = (ctla_r.output_mode_b != COM_OFF) &
                          !(is_pwm && ctla_r.output_mode_b == COM_TOGGLE);

    // interrupt flags: events set, vector or write-one clears, set wins
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            flags_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                logic clr;
                logic set;
                clr = (wr_go && i_avs_address == reg_addr(IDX_INT_FLAGS) && wd[i])
                      || i_irq_ack[i];
                set = (i == BIT_IRQ_CMPB) ? match_b
                    : (i == BIT_IRQ_CMPA) ? match_a : ovf_evt;
                if (set)      flags_r[i] <= 1'b1;
                else if (clr) flags_r[i] <= 1'b0;
            end
        end
    end

    // interrupt requests
    assign o_irq_req = irq_vec_t'(flags_r & irq_en_r & {3{i_global_irq_enable}});

endmodule : async_timer_ctrl

// [test/async_timer_ctrl_checker.sv]
// checker: bus handshake, read-back and interrupt gating of the timer control block
// assumes it is bound to async_timer_ctrl and sees only its ports
`timescale 1ns/100ps
module async_timer_ctrl_checker
    import async_timer_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic [9:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_global_irq_enable,
    input wire irq_vec_t    o_irq_req,
    input wire logic        o_crystal_osc_run,
    input wire logic        o_ext_clock_buf_en,
    input wire logic        o_shared_prescaler_reset
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // completed transfers and the register they address
    wire       rd_done = i_avs_read & ~o_avs_waitrequest;
    wire       wr_done = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
    wire [7:0] idx     = i_avs_address[9:2];
    wire [7:0] wd      = i_avs_writedata[7:0];
    first_wait_a: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
        else $error("request answered without a wait cycle");
    one_wait_a: assert property ((i_avs_read | i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("wait longer than one cycle");
    upper_zero_a: assert property (rd_done |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    ctrlb_zero_a: assert property (
        rd_done && idx == IDX_CTRL_B |-> o_avs_readdata[7:4] == 4'h0)
        else $error("force or reserved bits read as one");
    global_gate_a: assert property (!i_global_irq_enable |-> o_irq_req == 3'h0)
        else $error("request without global enable");
    mask_gate_a: assert property (
        wr_done && idx == IDX_INT_MASK && wd[2:0] == 3'h0 |=> o_irq_req == 3'h0)
        else $error("request with all enables cleared");
    osc_excl_a: assert property (o_ext_clock_buf_en |-> !o_crystal_osc_run)
        else $error("crystal runs with external clock");
    shared_pulse_a: assert property (
        wr_done && idx == IDX_GEN_CTRL && !wd[BIT_SYNC_MODE] && wd[BIT_PSR_SYNC]
        |=> o_shared_prescaler_reset ##1 !o_shared_prescaler_reset)
        else $error("shared prescaler reset not a one-cycle pulse");
    sync_hold_a: assert property (
        wr_done && idx == IDX_GEN_CTRL && wd[BIT_SYNC_MODE] && wd[BIT_PSR_SYNC]
        |=> o_shared_prescaler_reset [*3]) else $error("reset not held in sync mode");
    // main scenarios reached
    cover property (rd_done && idx == IDX_CTRL_B);
    cover property (o_irq_req != 3'h0);
    cover property (o_ext_clock_buf_en);
endmodule : async_timer_ctrl_checker

bind async_timer_ctrl async_timer_ctrl_checker checker_i (.i_ref_clk, .i_reset,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
    .o_avs_readdata, .o_avs_waitrequest, .i_global_irq_enable, .o_irq_req,
    .o_crystal_osc_run, .o_ext_clock_buf_en, .o_shared_prescaler_reset);

// [test/async_timer_ctrl_tb.sv]
// self-checking bench for the timer control block
// assumes the checker is bound in; the oscillator pin toggles every 8 clocks
`timescale 1ns/100ps
module async_timer_ctrl_tb;
    import async_timer_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, gie = 1'b0;
    logic [7:0]  idx = 8'h00, wd = 8'h00, v;
    irq_vec_t    ack = 3'h0, req;
    logic [31:0] rdata;
    logic        wait_r, out_a, out_b, en_a, en_b, osc_run, ext_en, sh_rst;
    int          cyc = 0, err_count = 0, cmp_count = 0;
    // clock, free oscillator pin and timeout
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    async_timer_ctrl dut (.i_ref_clk(clk), .i_reset(rst), .i_avs_address({idx, 2'h0}),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata({24'h0, wd}),
        .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
        .i_osc_input_pin(cyc[3]), .i_global_irq_enable(gie), .i_irq_ack(ack),
        .o_irq_req(req), .o_wave_out_a(out_a), .o_wave_out_b(out_b), .o_wave_en_a(en_a),
        .o_wave_en_b(en_b), .o_crystal_osc_run(osc_run), .o_ext_clock_buf_en(ext_en),
        .o_shared_prescaler_reset(sh_rst));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus transfer; a read is compared with exp
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        idx <= a;
        wd <= d;
        // hold the request until waitrequest is sampled low at a rising edge
        @(posedge clk);
        while (wait_r !== 1'b0) @(posedge clk);
        v = rdata[7:0];
        if (!w) chk(v, exp);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic t_regs;
        bus(1'b0, IDX_INT_MASK, 8'h00, RST_BYTE);
        bus(1'b0, IDX_ASYNC_STAT, 8'h00, RST_BYTE);
        bus(1'b0, 8'h00, 8'h00, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'hFF, 8'h00);
        bus(1'b0, IDX_CTRL_B, 8'h00, 8'h0F);
        bus(1'b1, IDX_CTRL_B, 8'h00, 8'h00);
        bus(1'b1, IDX_GEN_CTRL, 8'h03, 8'h00);
        bus(1'b0, IDX_GEN_CTRL, 8'h00, 8'h00);
        bus(1'b1, IDX_GEN_CTRL, 8'h83, 8'h00);
        @(negedge clk);
        chk({7'h0, sh_rst}, 8'h01);
        bus(1'b0, IDX_GEN_CTRL, 8'h00, 8'h83);
        bus(1'b1, IDX_GEN_CTRL, 8'h00, 8'h00);
        bus(1'b0, IDX_GEN_CTRL, 8'h00, 8'h00);
        $display("register test done");
    endtask : t_regs
    task automatic t_force;
        logic [7:0] am [5] = '{8'h50, 8'hA3, 8'hA0, 8'hF0, 8'h00};
        logic [7:0] pe [5] = '{8'h0F, 8'h0F, 8'h0A, 8'h0F, 8'h00};
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, IDX_CTRL_A, am[i], 8'h00);
            bus(1'b1, IDX_CTRL_B, 8'hC0, 8'h00);
            repeat (3) @(negedge clk);
            chk({4'h0, en_b, out_b & en_b, en_a, out_a & en_a}, pe[i]);
        end
        bus(1'b1, IDX_CTRL_A, 8'h03, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'h00, 8'h00);
        bus(1'b0, IDX_INT_FLAGS, 8'h00, 8'h00);
        $display("force test done");
    endtask : t_force
    task automatic t_irq;
        gie <= 1'b1;
        bus(1'b1, IDX_CMP_A, 8'h33, 8'h00);
        bus(1'b0, IDX_CMP_A, 8'h00, 8'h33);
        bus(1'b1, IDX_COUNT, 8'hFE, 8'h00);
        bus(1'b0, IDX_COUNT, 8'h00, 8'hFE);
        bus(1'b1, IDX_INT_MASK, 8'h07, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'h01, 8'h00);
        repeat (100) @(posedge clk);
        bus(1'b1, IDX_CTRL_B, 8'h00, 8'h00);
        bus(1'b0, IDX_INT_FLAGS, 8'h00, 8'h07);
        bus(1'b1, IDX_INT_MASK, 8'h01, 8'h00);
        @(negedge clk);
        chk({5'h0, req}, 8'h01);
        @(posedge clk);
        ack <= 3'h2;
        @(posedge clk);
        ack <= 3'h0;
        bus(1'b0, IDX_INT_FLAGS, 8'h00, 8'h05);
        bus(1'b1, IDX_INT_MASK, 8'h00, 8'h00);
        bus(1'b1, IDX_INT_FLAGS, 8'h05, 8'h00);
        bus(1'b0, IDX_INT_FLAGS, 8'h00, 8'h00);
        gie <= 1'b0;
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_async;
        bus(1'b1, IDX_ASYNC_STAT, 8'h40, 8'h00);
        bus(1'b1, IDX_ASYNC_STAT, 8'h60, 8'h00);
        @(negedge clk);
        chk({6'h0, ext_en, osc_run}, 8'h02);
        bus(1'b1, IDX_CMP_B, 8'h44, 8'h00);
        bus(1'b0, IDX_ASYNC_STAT, 8'h00, 8'h64);
        bus(1'b0, IDX_CMP_B, 8'h00, 8'h44);
        repeat (60) @(posedge clk);
        bus(1'b0, IDX_ASYNC_STAT, 8'h00, 8'h60);
        bus(1'b1, IDX_ASYNC_STAT, 8'h00, 8'h00);
        $display("async test done");
    endtask : t_async
    // counts and verdict
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_force();
        t_irq();
        t_async();
        wrap_up();
    end
endmodule : async_timer_ctrl_tb
